// *** pms_pkg.sv ***
// package of constants shared by the power mode sequencer ends
package pms_pkg;
   // control register field positions
   localparam int CtlPowerSave  = 0;
   localparam int CtlIdle       = 1;
   localparam int CtlHalt       = 2;
   localparam int CtlWaitSave   = 3;
   localparam int CtlMainDis    = 4;
   localparam int CtlPllDis     = 5;
   localparam int CtlHwMain     = 6;
   localparam int CtlHwPll      = 7;
   // status register field positions
   localparam int StSlowStable  = 0;
   localparam int StFastStable  = 1;
   localparam int StPllStable   = 2;
   // control reset value and fixed upper status bits
   localparam logic [7:0] CTL_RESET     = 8'h00;
   localparam logic [4:0] STATUS_UPPER  = 5'h00;
   // register indexes on the plain port
   localparam logic [1:0] ADDR_CONTROL  = 2'h0;
   localparam logic [1:0] ADDR_STATUS   = 2'h1;
   localparam logic [1:0] ADDR_MODE     = 2'h2;
   // wake unit size
   localparam int WAKE_CHANNELS = 32;
   localparam int WAKE_MODULE   = 16;
   localparam int WAKE_IRQS     = 8;
   // operating modes
   typedef enum logic [1:0] {PMS_ACTIVE, PMS_SAVE, PMS_IDLE, PMS_HALT}
      pms_mode_e;
endpackage

// *** pms_if.sv ***
// interface joining the sequencer with the core, clocks and wake unit
`timescale 1ns/10ps
interface pms_if;
   logic       waitExec;      // core executes wait, one-cycle pulse
   logic       wakeIn;        // latched wake request, async origin
   logic       nmiIn;         // non-maskable interrupt level
   logic       intAck;        // interrupt acknowledge pulse
   logic       slowOscStable; // low-frequency oscillator stable
   logic       fastOscStable; // high-frequency oscillator stable
   logic       pllLocked;     // pll stable when running
   logic       pllPowerDown;  // pll forced off by outside control
   logic       crystalAbsent; // no slow crystal fitted
   logic       fastOscEnable; // sequencer enables fast oscillator
   logic       pllEnable;     // sequencer enables pll
   logic       slowFromMain;  // slow clock from main prescaler
   logic       cpuClockGate;  // system clock runs
   logic [1:0] mode;          // current mode
   modport device (input waitExec, wakeIn, nmiIn, intAck, slowOscStable,
      fastOscStable, pllLocked, pllPowerDown, crystalAbsent,
      output fastOscEnable, pllEnable, slowFromMain, cpuClockGate, mode);
   modport host (output waitExec, wakeIn, nmiIn, intAck, slowOscStable,
      fastOscStable, pllLocked, pllPowerDown, crystalAbsent,
      input fastOscEnable, pllEnable, slowFromMain, cpuClockGate, mode);
endinterface

// *** pms_wake_sync.sv ***
// two-flop synchroniser for an asynchronously set level
`timescale 1ns/10ps
module pms_wake_sync
(
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst,
   // level in and out
   input  wire logic asyncIn,
   output logic      syncOut
);
   logic stage1; // first stage, read only by stage two

   // two-stage capture of the level
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         stage1  <= 1'b0;
         syncOut <= 1'b0;
      end
      else
      begin
         stage1  <= asyncIn; // RULE24
         syncOut <= stage1;
      end
   end
endmodule

// *** pms_host.sv ***
// core side end: drives wait, wake unit and clock-source stimuli
`timescale 1ns/10ps
module pms_host
(
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst,
   // link to the sequencer
   pms_if.host       link,
   // user side: core and clock sources
   input  wire logic waitReq,
   input  wire logic nmiReq,
   input  wire logic ackReq,
   input  wire logic slowOk,
   input  wire logic fastOk,
   input  wire logic pllOk,
   input  wire logic pllOff,
   input  wire logic noCrystal,
   input  wire logic [31:0] wakeLines,
   input  wire logic [31:0] wakeFalling,
   input  wire logic [31:0] wakeEnable,
   output logic [31:0] wakePending,
   output logic [1:0]  modeSeen
);
   logic [31:0] lastLines; // previous channel levels
   logic [31:0] edgeHit;   // selected edge seen this cycle

   // edge select per channel, two modules of sixteen
   always_comb
   begin
      edgeHit = wakeFalling & lastLines & ~wakeLines;
      edgeHit = edgeHit | (~wakeFalling & ~lastLines & wakeLines);
   end

   // pending latches, held until acknowledge or reset
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         lastLines   <= 32'h0000_0000;
         wakePending <= 32'h0000_0000;
      end
      else
      begin
         lastLines <= wakeLines;
         if (ackReq)
            wakePending <= edgeHit; // set wins over clear
         else
            wakePending <= wakePending | edgeHit; // RULE21 RULE22
      end
   end

   // drive the link
   always_comb
   begin
      link.waitExec      = waitReq;
      link.nmiIn         = nmiReq;
      link.intAck        = ackReq;
      link.wakeIn        = |(wakePending & wakeEnable); // RULE21
      link.slowOscStable = slowOk;
      link.fastOscStable = fastOk & link.fastOscEnable;
      link.pllLocked     = pllOk;
      link.pllPowerDown  = pllOff;
      link.crystalAbsent = noCrystal;
      modeSeen           = link.mode;
   end
endmodule

// *** pms_device.sv ***
// power mode sequencer: mode control, clock status and wake sequence
// How it works
// RULE1: status bit 0 slow stable; blocks low modes
// RULE2: status bit 1 fast stable; gates active
// RULE3: status bit 2 pll ok or off
// RULE4: upper status bits zero; low bits live
// RULE5: wake latched until acknowledge or reset
// RULE6: wake restores active, no restart itself
// RULE7: no wait-before: save starts now, flag later
// RULE8: wait-before: flag reads one, enter on wait
// RULE9: idle by bit then wait, from active/save; code also needs the wait-before bit set
// RULE10: halt by bit then wait, from active/save; code also needs the wait-before bit set
// RULE11: fast clock stops only after mode entered
// RULE12: fast osc on in active, off halt
// RULE13: software waits slow stable before save
// RULE14: clearing save returns active, flag lags
// RULE15: software reenables fast clock before leaving
// RULE16: wake: clear disables, wait stable, then active
// RULE17: wake goes straight to active from low
// RULE18: pending until needed clock stable
// RULE19: no crystal: slow from main, halt only; code also enters save and idle without a crystal
// RULE20: no crystal: exit to active, main-derived
// RULE21: wake channels pend and raise wake signal
// RULE22: wake detection works in every mode
// RULE23: control byte layout, clears on reset
// RULE24: wake signals synchronised by two flops
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
module pms_device
(
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // link to core, clocks and wake unit
   pms_if.device           link,
   // software register port
   input  wire logic [1:0] regAddr,
   input  wire logic [7:0] regWdata,
   input  wire logic       regWrite,
   input  wire logic       regRead,
   output logic      [7:0] regRdata
);
   typedef enum logic [2:0] {SQ_RUN, SQ_SAVE_GO, SQ_WAKE_FAST,
      SQ_WAKE_PLL, SQ_EXIT} pms_seq_e;

   pms_pkg::pms_mode_e mode;     // current mode
   pms_seq_e           seq;      // sequencer step
   logic [7:0]         ctl;      // control byte
   logic               wakeLat;  // latched wake request
   logic               wakeSync; // synchronised wake request
   logic               nmiSync;  // synchronised nmi
   logic               wakeHit;  // any hardware wake
   logic               pllOk;    // pll stable or powered down
   logic               lowMode;  // in save, idle or halt
   logic               ctlWr;    // control write strobe
   logic [7:0]         status;   // status byte

   // synchronise the asynchronous wake and nmi levels
   pms_wake_sync u_wakeSync
   (
      .mclk    (mclk),
      .rst     (rst),
      .asyncIn (link.wakeIn),
      .syncOut (wakeSync)
   );
   pms_wake_sync u_nmiSync
   (
      .mclk    (mclk),
      .rst     (rst),
      .asyncIn (link.nmiIn),
      .syncOut (nmiSync)
   );

   // derived conditions
   always_comb
   begin
      pllOk   = link.pllPowerDown | ~link.pllEnable | link.pllLocked; // RULE3
      lowMode = (mode != pms_pkg::PMS_ACTIVE);
      wakeHit = wakeLat & lowMode;
      ctlWr   = regWrite & (regAddr == pms_pkg::ADDR_CONTROL);
      status  = {pms_pkg::STATUS_UPPER, pllOk, link.fastOscStable,
                 link.slowOscStable}; // RULE1 RULE2 RULE4
   end

   // wake latch, held until acknowledge; new event wins over clear
   always_ff @(posedge mclk)
   begin
      if (rst)
         wakeLat <= 1'b0; // RULE5
      else if (wakeSync | nmiSync)
         wakeLat <= 1'b1; // RULE17
      else if (link.intAck)
         wakeLat <= 1'b0; // RULE5
   end

   // control byte and mode sequencer
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         ctl  <= pms_pkg::CTL_RESET; // RULE23
         mode <= pms_pkg::PMS_ACTIVE;
         seq  <= SQ_RUN;
      end
      else
      begin
         case (seq)
            // normal operation, software requests
            SQ_RUN:
            begin
               if (wakeHit)
               begin
                  ctl[pms_pkg::CtlMainDis] <= 1'b0; // RULE16
                  seq                      <= SQ_WAKE_FAST; // RULE17
               end
               else if (ctlWr)
               begin
                  ctl[7:3] <= regWdata[7:3];
                  // idle and halt bits are requests, held as written
                  ctl[pms_pkg::CtlIdle] <= regWdata[pms_pkg::CtlIdle];
                  ctl[pms_pkg::CtlHalt] <= regWdata[pms_pkg::CtlHalt];
                  if (regWdata[pms_pkg::CtlPowerSave] && !lowMode)
                  begin
                     if (regWdata[pms_pkg::CtlWaitSave])
                        ctl[pms_pkg::CtlPowerSave] <= 1'b1; // RULE8
                     else
                        seq <= SQ_SAVE_GO; // RULE7
                  end
                  else if (!regWdata[pms_pkg::CtlPowerSave]
                           && mode == pms_pkg::PMS_SAVE)
                     seq <= SQ_EXIT; // RULE14
                  else if (!regWdata[pms_pkg::CtlPowerSave])
                     ctl[pms_pkg::CtlPowerSave] <= 1'b0;
               end
               else if (link.waitExec && ctl[pms_pkg::CtlWaitSave]
                        && link.slowOscStable
                        && (mode == pms_pkg::PMS_ACTIVE
                            || mode == pms_pkg::PMS_SAVE)) // RULE1
               begin
                  if (ctl[pms_pkg::CtlHalt])
                     mode <= pms_pkg::PMS_HALT; // RULE10
                  else if (ctl[pms_pkg::CtlIdle])
                     mode <= pms_pkg::PMS_IDLE; // RULE9
                  else if (ctl[pms_pkg::CtlPowerSave])
                     mode <= pms_pkg::PMS_SAVE; // RULE8
               end
            end
            // immediate save waits for a stable slow clock
            SQ_SAVE_GO:
            begin
               if (wakeHit || link.slowOscStable) // RULE18
               begin
                  mode                       <= pms_pkg::PMS_SAVE;
                  ctl[pms_pkg::CtlPowerSave] <= 1'b1; // RULE7
                  seq                        <= SQ_RUN;
               end
            end
            // wake: fast oscillator first, then the pll
            SQ_WAKE_FAST:
            begin
               if (link.fastOscStable)
               begin
                  ctl[pms_pkg::CtlPllDis] <= 1'b0; // RULE16
                  seq                     <= SQ_WAKE_PLL;
               end
            end
            SQ_WAKE_PLL:
            begin
               if (pllOk)
                  seq <= SQ_EXIT; // RULE16
            end
            // enter active once fast clock and pll are good
            SQ_EXIT:
            begin
               if (link.fastOscStable && pllOk) // RULE2 RULE3 RULE18
               begin
                  mode                       <= pms_pkg::PMS_ACTIVE; // RULE6
                  ctl[pms_pkg::CtlPowerSave] <= 1'b0; // RULE14
                  ctl[pms_pkg::CtlIdle]      <= 1'b0;
                  ctl[pms_pkg::CtlHalt]      <= 1'b0;
                  ctl[pms_pkg::CtlHwMain]    <= 1'b0;
                  ctl[pms_pkg::CtlHwPll]     <= 1'b0;
                  seq                        <= SQ_RUN;
               end
            end
            default:
               seq <= SQ_RUN;
         endcase
      end
   end

   // clock enables from mode and disable bits
   always_comb
   begin
      case (mode)
         pms_pkg::PMS_ACTIVE:
         begin
            link.fastOscEnable = 1'b1; // RULE12
            link.pllEnable     = 1'b1;
         end
         pms_pkg::PMS_HALT:
         begin
            // oscillator restarts only once a wake sequence runs,
            // otherwise the wake would wait forever for a stable clock
            link.fastOscEnable = (seq != SQ_RUN); // RULE12 RULE16
            link.pllEnable     = 1'b0;
         end
         default:
         begin
            // only once in save or idle; never without a crystal
            link.fastOscEnable = ~ctl[pms_pkg::CtlMainDis]
                                 | link.crystalAbsent; // RULE11 RULE19
            link.pllEnable     = ~ctl[pms_pkg::CtlPllDis]; // RULE11
         end
      endcase
      link.slowFromMain = link.crystalAbsent; // RULE19 RULE20
      link.cpuClockGate = (mode == pms_pkg::PMS_ACTIVE)
                          || (mode == pms_pkg::PMS_SAVE);
      link.mode         = mode;
   end

   // read data one cycle after the strobe
   always_ff @(posedge mclk)
   begin
      if (rst)
         regRdata <= 8'h00;
      else if (regRead)
      begin
         case (regAddr)
            pms_pkg::ADDR_CONTROL: regRdata <= ctl;
            pms_pkg::ADDR_STATUS:  regRdata <= status;
            pms_pkg::ADDR_MODE:    regRdata <= {6'h00, mode};
            default:               regRdata <= 8'h00;
         endcase
      end
   end
endmodule

// *** pms_props.sv ***
// assertion checker watching the sequencer link signals
`timescale 1ns/10ps
module pms_props
(
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // link signals
   input  wire logic       waitExec,
   input  wire logic       wakeIn,
   input  wire logic       nmiIn,
   input  wire logic       slowOscStable,
   input  wire logic       fastOscStable,
   input  wire logic       crystalAbsent,
   input  wire logic       fastOscEnable,
   input  wire logic       pllEnable,
   input  wire logic       slowFromMain,
   input  wire logic       cpuClockGate,
   input  wire logic [1:0] mode
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // either wake source
   wire logic wakeAny = wakeIn | nmiIn;
   logic      haltWoken; // wake source seen since halt was entered

   // remembers a wake inside the present halt stay
   always_ff @(posedge mclk)
   begin
      if (rst || mode != 2'h3)
         haltWoken <= 1'b0;
      else if (wakeAny)
         haltWoken <= 1'b1;
   end

   a_halt_clocks_off: assert property
      ((mode == 2'h3 && !haltWoken) |->
      !fastOscEnable && !pllEnable && !cpuClockGate) else $error("halt clk");
   a_halt_wake_osc: assert property
      ((mode == 2'h3 && $rose(wakeAny)) |-> ##[3:8] fastOscEnable)
      else $error("halt wake osc off");
   a_active_fast_on: assert property (mode == 2'h0 |->
      fastOscEnable) else $error("active fast off");
   a_low_needs_slow: assert property ((mode == 2'h0 ##1 mode != 2'h0)
      |-> $past(slowOscStable)) else $error("low mode without slow");
   a_active_needs_fast: assert property ((mode != 2'h0 ##1 mode == 2'h0)
      |-> $past(fastOscStable)) else $error("active without fast");
   a_deep_from_wait: assert property
      ((mode > 2'h1 && mode != $past(mode)) |->
      $past(waitExec) && $past(mode) < 2'h2) else $error("bad deep entry");
   a_wait_slow_refuse: assert property
      ((mode == 2'h0 && waitExec && !slowOscStable) |=> mode == 2'h0)
      else $error("wait taken without slow");
   a_wake_exits: assert property (($rose(wakeAny) && mode != 2'h0)
      |-> ##[4:60] mode == 2'h0) else $error("wake no exit");
   a_wake_sync_delay: assert property (($rose(wakeAny) && mode != 2'h0)
      |-> ##1 (mode != 2'h0) [*3]) else $error("wake too early");
   a_no_xtal_main: assert property ((crystalAbsent ##1 crystalAbsent)
      |-> slowFromMain) else $error("slow not from main");
   a_no_xtal_fast: assert property
      ((crystalAbsent && (mode == 2'h1 || mode == 2'h2)) |-> fastOscEnable)
      else $error("main clock off without crystal");

   // main scenarios reached
   c_halt: cover property (mode == 2'h3);
   c_idle: cover property (mode == 2'h2);
   c_wake: cover property (($rose(wakeAny) && mode != 2'h0) ##[4:60] mode == 2'h0);
endmodule

// *** tb_power_mode_sequencer.sv ***
// self-checking bench for the two sequencer ends
`timescale 1ns/10ps
`define CHK(nm, ex, gt) \
   begin \
      tests_run++; \
      if ((gt) !== (ex)) \
      begin \
         fail_count++; \
         $display("CHECK FAILED %s exp %0h got %0h", nm, ex, gt); \
      end \
   end
module tb_power_mode_sequencer;
   logic        mclk, rst, waitReq, nmiReq, ackReq, regWrite, regRead;
   logic        slowOk, fastOk, pllOk, pllOff, noCrystal;
   logic [31:0] wakeLines, wakeFalling, wakeEnable, wakePending;
   logic [1:0]  modeSeen, regAddr;
   logic [7:0]  regWdata, regRdata, rd;
   int          fail_count = 0, tests_run = 0, cycles = 0, k;
   pms_if       bus ();

   pms_host pms_host_inst (.mclk(mclk), .rst(rst), .link(bus),
      .waitReq(waitReq), .nmiReq(nmiReq), .ackReq(ackReq), .slowOk(slowOk),
      .fastOk(fastOk), .pllOk(pllOk), .pllOff(pllOff), .noCrystal(noCrystal),
      .wakeLines(wakeLines), .wakeFalling(wakeFalling),
      .wakeEnable(wakeEnable), .wakePending(wakePending), .modeSeen(modeSeen));
   pms_device pms_device_inst (.mclk(mclk), .rst(rst), .link(bus),
      .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
      .regRead(regRead), .regRdata(regRdata));
   pms_props pms_props_inst (.mclk(mclk), .rst(rst),
      .waitExec(bus.waitExec), .wakeIn(bus.wakeIn), .nmiIn(bus.nmiIn),
      .slowOscStable(bus.slowOscStable), .fastOscStable(bus.fastOscStable),
      .crystalAbsent(bus.crystalAbsent), .fastOscEnable(bus.fastOscEnable),
      .pllEnable(bus.pllEnable), .slowFromMain(bus.slowFromMain),
      .cpuClockGate(bus.cpuClockGate), .mode(bus.mode));

   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // one-cycle strobes on the plain register port
   task automatic ctl_wr(input logic [7:0] d);
      @(posedge mclk);
      regAddr  <= pms_pkg::ADDR_CONTROL;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge mclk);
      regWrite <= 1'b0;
   endtask
   task automatic reg_rd(input logic [1:0] a);
      @(posedge mclk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge mclk);
      regRead <= 1'b0;
      #1;
      rd = regRdata;
   endtask
   task automatic pulse_wait();
      @(posedge mclk);
      waitReq <= 1'b1;
      @(posedge mclk);
      waitReq <= 1'b0;
   endtask
   // bounded wait for a mode, then compare
   task automatic wait_mode(input logic [1:0] m);
      for (int i = 0; i < 80 && modeSeen !== m; i++)
      begin
         @(posedge mclk);
         #1;
      end
      `CHK("mode", m, modeSeen)
   endtask
   // nmi wake back to active, then acknowledge
   task automatic wake_nmi();
      @(posedge mclk);
      nmiReq <= 1'b1;
      wait_mode(pms_pkg::PMS_ACTIVE);
      @(posedge mclk);
      nmiReq <= 1'b0;
      // drain the synchroniser so the acknowledge really clears
      repeat (3) @(posedge mclk);
      ackReq <= 1'b1;
      @(posedge mclk);
      ackReq <= 1'b0;
   endtask
   // status byte expected in active mode
   function automatic logic [7:0] exp_st(logic s, f, p, off);
      return {5'h00, off | p, f, s};
   endfunction
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // hang guard
   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         fail_count++;
         report_and_stop();
      end
   end

   initial
   begin
      {waitReq, nmiReq, ackReq, regWrite, regRead, pllOff, noCrystal} = '0;
      {slowOk, fastOk, pllOk, rst, regAddr, regWdata} = '1;
      {wakeLines, wakeFalling, wakeEnable} = '0;
      k = $urandom(95853);
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      reg_rd(pms_pkg::ADDR_CONTROL);
      `CHK("control", pms_pkg::CTL_RESET, rd)
      reg_rd(2'h3);
      `CHK("unmapped", 8'h00, rd)
      for (int i = 0; i < 10; i++)
      begin
         {slowOk, fastOk, pllOk, pllOff} <= (i < 2) ? 4'(i * 15) : 4'($urandom);
         repeat (4) @(posedge mclk);
         reg_rd(pms_pkg::ADDR_STATUS);
         `CHK("status", exp_st(slowOk, fastOk, pllOk, pllOff), rd)
      end
      {slowOk, fastOk, pllOk, pllOff, noCrystal} <= 5'h1d;
      $display("status test done");
      reg_rd(pms_pkg::ADDR_STATUS);
      `CHK("slow ready", 1'b1, rd[pms_pkg::StSlowStable])
      ctl_wr(8'h01);
      wait_mode(pms_pkg::PMS_SAVE);
      reg_rd(pms_pkg::ADDR_CONTROL);
      `CHK("psm set", 1'b1, rd[0])
      fastOk <= 1'b0;
      ctl_wr(8'h00);
      repeat (10) @(posedge mclk);
      reg_rd(pms_pkg::ADDR_CONTROL);
      `CHK("psm held", 1'b1, rd[0])
      `CHK("save held", 2'h1, modeSeen)
      fastOk <= 1'b1;
      reg_rd(pms_pkg::ADDR_STATUS);
      `CHK("fast ready", 1'b1, rd[pms_pkg::StFastStable])
      wait_mode(pms_pkg::PMS_ACTIVE);
      `CHK("main slow", 1'b1, bus.slowFromMain)
      {noCrystal, slowOk} <= 2'h0;
      ctl_wr(8'h01);
      repeat (10) @(posedge mclk);
      `CHK("no save", 2'h0, modeSeen)
      slowOk <= 1'b1;
      wait_mode(pms_pkg::PMS_SAVE);
      ctl_wr(8'h00);
      wait_mode(pms_pkg::PMS_ACTIVE);
      $display("immediate save test done");
      ctl_wr(8'h09);
      reg_rd(pms_pkg::ADDR_CONTROL);
      `CHK("psm early", 1'b1, rd[0])
      `CHK("not yet", 2'h0, modeSeen)
      pulse_wait();
      wait_mode(pms_pkg::PMS_SAVE);
      wake_nmi();
      reg_rd(pms_pkg::ADDR_CONTROL);
      `CHK("ctl woke", 8'h08, rd)
      for (int b = 1; b <= 2; b++)
      begin
         ctl_wr(8'(1 << b));
         pulse_wait();
         repeat (4) @(posedge mclk);
         `CHK("no wait_before_save", 2'h0, modeSeen)
         ctl_wr(8'h38 | 8'(1 << b));
         `CHK("fast on", 1'b1, bus.fastOscEnable)
         pulse_wait();
         wait_mode(2'(b + 1));
         `CHK("fast off", 1'b0, bus.fastOscEnable)
         wake_nmi();
         reg_rd(pms_pkg::ADDR_CONTROL);
         `CHK("ctl woke", 8'h08, rd)
      end
      $display("deep mode test done");
      k = $urandom_range(31, 0);
      wakeEnable[k] <= 1'b1;
      ctl_wr(8'h01);
      wait_mode(pms_pkg::PMS_SAVE);
      wakeLines[k] <= 1'b1;
      wait_mode(pms_pkg::PMS_ACTIVE);
      `CHK("pending", 1'b1, wakePending[k])
      $display("channel wake test done");
      report_and_stop();
   end
endmodule
